//--- rtl/cfs_defines.svh
// Purpose: Offsets, field positions, reset values for the CAN FD status block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef CFS_DEFINES_SVH
`define CFS_DEFINES_SVH

`define CFS_NUM_FIFO        7
`define CFS_OFF_FIFO_UA_H0  12'h000
`define CFS_OFF_FIFO_UA_L0  12'h004
`define CFS_OFF_EVT_UA_H    12'h040
`define CFS_OFF_EVT_UA_L    12'h044
`define CFS_OFF_TXQ_UA_H    12'h048
`define CFS_OFF_TXQ_UA_L    12'h04c
`define CFS_OFF_ERR_FLAGS   12'h050
`define CFS_OFF_ERR_CNT     12'h054
`define CFS_OFF_DP_ERR_CNT  12'h058
`define CFS_OFF_MODE        12'h05c
`define CFS_OFF_FIFO_DIR    12'h060
`define CFS_OFF_INT_STAT    12'h064
`define CFS_OFF_INT_MASK    12'h068

`define CFS_BIT_BUS_OFF     5
`define CFS_BIT_TX_PASSIVE  4
`define CFS_BIT_RX_PASSIVE  3
`define CFS_BIT_TX_WARN     2
`define CFS_BIT_RX_WARN     1
`define CFS_BIT_ANY_WARN    0

`define CFS_MODE_CONFIG     3'h4
`define CFS_MODE_NORMAL     3'h0
`define CFS_WARN_ABOVE      9'h05f
`define CFS_PASSIVE_ABOVE   9'h07f
`define CFS_BUS_OFF_ABOVE   9'h0ff
`define CFS_FIFO_STRIDE     16'h0048
`define CFS_FIFO_DEPTH      3'h7
`define CFS_RAM_BASE        32'h0000_0000
`define CFS_EVT_BASE        32'h0000_0400
`define CFS_TXQ_BASE        32'h0000_0600
`define CFS_EVT_STRIDE      16'h000c
`define CFS_RECOVER_BITS    11'h580

`endif

//--- rtl/cfs_err_counter.sv
// Purpose: Fault-confinement counter pair for one bit-rate phase.
// Assumes: Error events are one-cycle pulses from the protocol engine.
// Notes:   Counts are nine bits wide so bus-off above 255 is visible.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defines.svh"
module cfs_err_counter
    import cfs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tx_err,
    input  wire logic       tx_ok,
    input  wire logic       rx_err,
    input  wire logic       rx_err_major,
    input  wire logic       rx_ok,
    input  wire logic       recover,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_tx,
    input  wire logic [7:0] wr_rx,
    output cfs_cnt9_t       tx_cnt,
    output cfs_cnt9_t       rx_cnt
);
    typedef struct packed {
        cfs_cnt9_t tx;
        cfs_cnt9_t rx;
    } cfs_cnt_t;

    cfs_cnt_t s_r;
    cfs_cnt_t s_nxt;

    // Transmit errors add 8, success subtracts 1; receive errors add 1
    // or 8, success subtracts 1, or drops to 119 from above 127.
    always_comb begin
        s_nxt = s_r;
        if (recover) begin
            s_nxt = '0;
        end else if (wr_en) begin
            s_nxt.tx = {1'b0, wr_tx};
            s_nxt.rx = {1'b0, wr_rx};
        end else begin
            if (tx_err && s_r.tx <= `CFS_BUS_OFF_ABOVE) begin
                s_nxt.tx = s_r.tx + 9'h008;
            end else if (tx_ok && s_r.tx != 9'h000 &&
                         s_r.tx <= `CFS_BUS_OFF_ABOVE) begin
                s_nxt.tx = s_r.tx - 9'h001;
            end
            if (rx_err_major) begin
                s_nxt.rx = (s_r.rx > 9'h0f7) ? 9'h0ff : s_r.rx + 9'h008;
            end else if (rx_err) begin
                s_nxt.rx = (s_r.rx == 9'h0ff) ? 9'h0ff : s_r.rx + 9'h001;
            end else if (rx_ok) begin
                if (s_r.rx > `CFS_PASSIVE_ABOVE) begin
                    s_nxt.rx = 9'h077;
                end else if (s_r.rx != 9'h000) begin
                    s_nxt.rx = s_r.rx - 9'h001;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_cnt = s_r.tx;
    assign rx_cnt = s_r.rx;
endmodule
`default_nettype wire

//--- rtl/cfs_pkg.sv
// Purpose: Types for the CAN FD status block.
// Assumes: Nothing beyond the defines header.
// Notes:   Error states are one-hot.
package cfs_pkg;
    typedef enum logic [2:0] {
        CFS_ACTIVE  = 3'b001,
        CFS_PASSIVE = 3'b010,
        CFS_BUSOFF  = 3'b100
    } cfs_err_state_t;

    typedef logic [8:0] cfs_cnt9_t;
endpackage

//--- rtl/cfs_ring_ptr.sv
// Purpose: One message ring: head and tail index and the user address.
// Assumes: Push and pop come from same-clock logic.
// Notes:   Transmit rings expose the head, receive rings the tail.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defines.svh"
module cfs_ring_ptr
    import cfs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic        flush,
    input  wire logic        show_head,
    input  wire logic [31:0] base,
    input  wire logic [15:0] stride,
    output logic      [31:0] user_addr
);
    typedef struct packed {
        logic [2:0] head;
        logic [2:0] tail;
    } cfs_ring_t;

    cfs_ring_t s_r;
    cfs_ring_t s_nxt;
    logic [2:0] idx;

    // Indices wrap at the ring depth; a flush empties the ring.
    always_comb begin
        s_nxt = s_r;
        if (flush) begin
            s_nxt = '0;
        end else begin
            if (push) begin
                s_nxt.head = (s_r.head == `CFS_FIFO_DEPTH) ? 3'h0
                                                           : s_r.head + 3'h1;
            end
            if (pop) begin
                s_nxt.tail = (s_r.tail == `CFS_FIFO_DEPTH) ? 3'h0
                                                           : s_r.tail + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // The address is combinational; the top registers it on read.
    assign idx       = show_head ? s_r.head : s_r.tail;
    assign user_addr = base + 32'(stride * {13'h0, idx});
endmodule
`default_nettype wire

//--- rtl/cfs_status_top.sv
// Purpose: CAN FD user addresses, error counters and error state flags.
// Assumes: Protocol events arrive as one-cycle pulses on pclk.
// Notes:   APB slave, zero wait states, unmapped reads return zero.
//
// Contract
// - Transmit FIFO user address shows head.
// - Receive FIFO user address shows tail.
// - FIFO user address split high/low halves.
// - Event FIFO user address shows tail.
// - Transmit queue user address shows head.
// - Mode code 100 is Configuration mode.
// - Bus-off above 255, resets to one.
// - Bus-off reads set in Configuration mode.
// - Transmit passive when count above 127.
// - Receive passive when count above 127.
// - Transmit warning when count 96 to 127.
// - Receive warning when count 96 to 127.
// - Combined warning is transmit or receive warning.
// - Nominal counters in 15:8 and 7:0.
// - Writable data-phase counters, same layout.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defines.svh"
module cfs_status_top
    import cfs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [6:0]  fifo_push,
    input  wire logic [6:0]  fifo_pop,
    input  wire logic        evt_push,
    input  wire logic        evt_pop,
    input  wire logic        txq_push,
    input  wire logic        txq_pop,
    input  wire logic        nom_tx_err,
    input  wire logic        nom_tx_ok,
    input  wire logic        nom_rx_err,
    input  wire logic        nom_rx_err_major,
    input  wire logic        nom_rx_ok,
    input  wire logic        dp_tx_err,
    input  wire logic        dp_tx_ok,
    input  wire logic        dp_rx_err,
    input  wire logic        dp_rx_ok,
    input  wire logic        bus_idle_bit,
    output logic             irq,
    output logic             bus_off_out
);
    typedef struct packed {
        logic [2:0]     operating_mode_select;
        logic [6:0]     fifo_direction_transmit;
        logic [5:0]     int_stat;
        logic [5:0]     int_mask;
        logic [5:0]     flags_prev;
        logic [10:0]    recover_cnt;
        cfs_err_state_t err_state;
        logic [31:0]    prdata;
        logic           irq;
        logic           bus_off;
    } cfs_top_t;

    cfs_top_t s_r;
    cfs_top_t s_nxt;

    logic        in_config;
    logic        wr_acc;
    logic        rd_acc;
    logic        dp_wr;
    logic        recover;
    logic [5:0]  flags;
    logic [5:0]  stat_clr;
    logic [31:0] rd_word;
    logic [31:0] fifo_ua   [`CFS_NUM_FIFO];
    logic [31:0] evt_ua;
    logic [31:0] txq_ua;
    cfs_cnt9_t   nom_tx;
    cfs_cnt9_t   nom_rx;
    cfs_cnt9_t   dp_tx;
    cfs_cnt9_t   dp_rx;

    assign in_config = (s_r.operating_mode_select == `CFS_MODE_CONFIG);
    assign wr_acc    = psel && penable && pwrite;
    assign rd_acc    = psel && !penable && !pwrite;
    assign dp_wr     = wr_acc && paddr == `CFS_OFF_DP_ERR_CNT
                       && pstrb[1:0] == 2'b11;
    assign recover   = s_r.err_state == CFS_BUSOFF
                       && s_r.recover_cnt == `CFS_RECOVER_BITS;
    assign stat_clr  = (wr_acc && paddr == `CFS_OFF_INT_STAT)
                       ? pwdata[5:0] : 6'h00;

    // One ring per FIFO; direction bit picks head or tail for the view.
    genvar gi;
    generate
        for (gi = 0; gi < `CFS_NUM_FIFO; gi++) begin : g_fifo
            cfs_ring_ptr u_ring (
                .pclk      (pclk),
                .presetn   (presetn),
                .push      (fifo_push[gi]),
                .pop       (fifo_pop[gi]),
                .flush     (in_config),
                .show_head (s_r.fifo_direction_transmit[gi]),
                .base      (`CFS_RAM_BASE + 32'(gi) * 32'h0000_0080),
                .stride    (`CFS_FIFO_STRIDE),
                .user_addr (fifo_ua[gi])
            );
        end
    endgenerate

    // The event FIFO is drained by software, so its tail is shown.
    cfs_ring_ptr u_evt (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (evt_push),
        .pop       (evt_pop),
        .flush     (in_config),
        .show_head (1'b0),
        .base      (`CFS_EVT_BASE),
        .stride    (`CFS_EVT_STRIDE),
        .user_addr (evt_ua)
    );

    // The queue is filled by software, so its head is shown.
    cfs_ring_ptr u_txq (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (txq_push),
        .pop       (txq_pop),
        .flush     (in_config),
        .show_head (1'b1),
        .base      (`CFS_TXQ_BASE),
        .stride    (`CFS_FIFO_STRIDE),
        .user_addr (txq_ua)
    );

    // Nominal counters; events are ignored off the bus.
    cfs_err_counter u_nom (
        .pclk         (pclk),
        .presetn      (presetn),
        .tx_err       (nom_tx_err && !in_config),
        .tx_ok        (nom_tx_ok && !in_config),
        .rx_err       (nom_rx_err && !in_config),
        .rx_err_major (nom_rx_err_major && !in_config),
        .rx_ok        (nom_rx_ok && !in_config),
        .recover      (recover),
        .wr_en        (1'b0),
        .wr_tx        (8'h00),
        .wr_rx        (8'h00),
        .tx_cnt       (nom_tx),
        .rx_cnt       (nom_rx)
    );

    // Data-phase counters, also loadable by software.
    cfs_err_counter u_dp (
        .pclk         (pclk),
        .presetn      (presetn),
        .tx_err       (dp_tx_err && !in_config),
        .tx_ok        (dp_tx_ok && !in_config),
        .rx_err       (dp_rx_err && !in_config),
        .rx_err_major (1'b0),
        .rx_ok        (dp_rx_ok && !in_config),
        .recover      (recover),
        .wr_en        (dp_wr),
        .wr_tx        (pwdata[15:8]),
        .wr_rx        (pwdata[7:0]),
        .tx_cnt       (dp_tx),
        .rx_cnt       (dp_rx)
    );

    // Derived error state flags from the nominal counters; bus-off is also set in Configuration mode.
    always_comb begin
        flags = 6'h00;
        flags[`CFS_BIT_BUS_OFF]    = nom_tx > `CFS_BUS_OFF_ABOVE
                                     || in_config;
        flags[`CFS_BIT_TX_PASSIVE] = nom_tx > `CFS_PASSIVE_ABOVE;
        flags[`CFS_BIT_RX_PASSIVE] = nom_rx > `CFS_PASSIVE_ABOVE;
        flags[`CFS_BIT_TX_WARN]    = nom_tx > `CFS_WARN_ABOVE
                                     && nom_tx <= `CFS_PASSIVE_ABOVE;
        flags[`CFS_BIT_RX_WARN]    = nom_rx > `CFS_WARN_ABOVE
                                     && nom_rx <= `CFS_PASSIVE_ABOVE;
        flags[`CFS_BIT_ANY_WARN]   = flags[`CFS_BIT_TX_WARN]
                                     || flags[`CFS_BIT_RX_WARN];
    end

    // Read mux; reads decode the same way in Configuration mode as in any other mode.
    always_comb begin
        rd_word = 32'h0000_0000;
        for (int i = 0; i < `CFS_NUM_FIFO; i++) begin
            if (paddr == `CFS_OFF_FIFO_UA_H0 + 12'(i * 8)) begin
                rd_word = {16'h0000, fifo_ua[i][31:16]};
            end
            if (paddr == `CFS_OFF_FIFO_UA_L0 + 12'(i * 8)) begin
                rd_word = {16'h0000, fifo_ua[i][15:0]};
            end
        end
        unique case (paddr)
            `CFS_OFF_EVT_UA_H:   rd_word = {16'h0000, evt_ua[31:16]};
            `CFS_OFF_EVT_UA_L:   rd_word = {16'h0000, evt_ua[15:0]};
            `CFS_OFF_TXQ_UA_H:   rd_word = {16'h0000, txq_ua[31:16]};
            `CFS_OFF_TXQ_UA_L:   rd_word = {16'h0000, txq_ua[15:0]};
            `CFS_OFF_ERR_FLAGS:  rd_word = {26'h0, flags};
            `CFS_OFF_ERR_CNT:    rd_word = {16'h0, nom_tx[7:0],
                                            nom_rx[7:0]};
            `CFS_OFF_DP_ERR_CNT: rd_word = {16'h0, dp_tx[7:0], dp_rx[7:0]};
            `CFS_OFF_MODE:       rd_word = {29'h0, s_r.operating_mode_select};
            `CFS_OFF_FIFO_DIR:   rd_word = {25'h0,
                                            s_r.fifo_direction_transmit};
            `CFS_OFF_INT_STAT:   rd_word = {26'h0, s_r.int_stat};
            `CFS_OFF_INT_MASK:   rd_word = {26'h0, s_r.int_mask};
            default:             ;
        endcase
    end

    // Control registers, sticky events, bus-off recovery counting.
    always_comb begin
        s_nxt = s_r;
        if (rd_acc) begin
            s_nxt.prdata = rd_word;
        end
        if (wr_acc && pstrb[0]) begin
            if (paddr == `CFS_OFF_MODE) begin
                s_nxt.operating_mode_select = pwdata[2:0];
            end
            if (paddr == `CFS_OFF_FIFO_DIR && in_config) begin
                s_nxt.fifo_direction_transmit = pwdata[6:0];
            end
            if (paddr == `CFS_OFF_INT_MASK) begin
                s_nxt.int_mask = pwdata[5:0];
            end
        end
        // A rising flag in the same cycle as its clear stays set.
        s_nxt.flags_prev = flags;
        s_nxt.int_stat   = (s_r.int_stat & ~stat_clr)
                           | (flags & ~s_r.flags_prev);
        // Bus-off waits 128 x 11 recessive bits before returning active.
        unique case (s_r.err_state)
            CFS_ACTIVE, CFS_PASSIVE: begin
                s_nxt.recover_cnt = 11'h000;
                s_nxt.err_state   = (nom_tx > `CFS_BUS_OFF_ABOVE)
                                    ? CFS_BUSOFF
                                    : (flags[`CFS_BIT_TX_PASSIVE]
                                       || flags[`CFS_BIT_RX_PASSIVE])
                                      ? CFS_PASSIVE : CFS_ACTIVE;
            end
            CFS_BUSOFF: begin
                if (recover) begin
                    s_nxt.err_state = CFS_ACTIVE;
                end else if (bus_idle_bit && !in_config) begin
                    s_nxt.recover_cnt = s_r.recover_cnt + 11'h001;
                end
            end
            default: s_nxt.err_state = CFS_ACTIVE;
        endcase
        s_nxt.irq     = |(s_nxt.int_stat & s_nxt.int_mask);
        s_nxt.bus_off = flags[`CFS_BIT_BUS_OFF];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r                         <= '0;
            s_r.operating_mode_select   <= `CFS_MODE_CONFIG;
            s_r.err_state               <= CFS_ACTIVE;
            s_r.flags_prev              <= 6'h20;
            s_r.bus_off                 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata      = s_r.prdata;
    assign pready      = 1'b1;
    assign pslverr     = 1'b0;
    assign irq         = s_r.irq;
    assign bus_off_out = s_r.bus_off;
endmodule
`default_nettype wire

//--- sim/cfs_can_node.sv
// Purpose: Other nodes on the bus, seen as protocol event pulses.
// Assumes: Called just after a rising edge of pclk.
// Notes:   Gap zero gives back-to-back events, else spaced ones.
`timescale 1ns/1ps
`default_nettype none
module cfs_can_node (
    input wire logic       pclk,
    output var logic [9:0] ev
);
    initial ev = 10'h000;
    // Holding the line high avoids two assignments in one time step.
    task pulse(input int k, input int n, input int gap);
        if (gap == 0) begin
            ev[k] <= 1'b1;
            repeat (n) @(posedge pclk);
            ev[k] <= 1'b0;
            @(posedge pclk);
        end else begin
            repeat (n) begin
                ev[k] <= 1'b1;
                @(posedge pclk);
                ev[k] <= 1'b0;
                repeat (gap) @(posedge pclk);
            end
        end
    endtask
endmodule
`default_nettype wire

//--- sim/cfs_status_checker.sv
// Purpose: Port-level checks on the CAN FD status block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to the top module from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module cfs_status_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        nom_tx_err,
    input wire logic        bus_idle_bit,
    input wire logic        irq,
    input wire logic        bus_off_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded bus cycles; the mode and mask writes are the causes we track.
    logic rd_set;
    logic wr_mode;
    logic wr_mask0;
    assign rd_set = psel && !penable && !pwrite;
    assign wr_mode = psel && penable && pwrite && paddr == 12'h05c && pstrb[0];
    assign wr_mask0 = psel && penable && pwrite && paddr == 12'h068
                      && pstrb[0] && pwdata[5:0] == 6'h00;
    property p_ready_always;
        pready && !pslverr;
    endproperty
    a_ready_always: assert property (p_ready_always) else $error("bus answer");
    property p_busoff_reset;
        !$past(presetn) |-> bus_off_out;
    endproperty
    a_busoff_reset: assert property (p_busoff_reset) else $error("boff rst");
    property p_busoff_fall;
        $fell(bus_off_out) |-> $past(wr_mode) || $past(wr_mode, 2)
            || $past(bus_idle_bit, 2) || $past(bus_idle_bit, 3);
    endproperty
    a_busoff_fall: assert property (p_busoff_fall) else $error("boff fall");
    property p_busoff_rise;
        $rose(bus_off_out) |-> $past(nom_tx_err) || $past(nom_tx_err, 2)
            || $past(wr_mode) || $past(wr_mode, 2);
    endproperty
    a_busoff_rise: assert property (p_busoff_rise) else $error("boff rise");
    property p_cfg_busoff;
        wr_mode && pwdata[2:0] == 3'h4 |=> ##[0:2] bus_off_out;
    endproperty
    a_cfg_busoff: assert property (p_cfg_busoff) else $error("cfg boff");
    property p_flags_read;
        rd_set && paddr == 12'h050 |=> prdata[31:6] == 26'h0
            && prdata[0] == (prdata[1] || prdata[2]);
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("flags");
    property p_cnt_read;
        rd_set && paddr == 12'h054 |=> prdata[31:16] == 16'h0;
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("counters");
    property p_unmapped;
        rd_set && paddr == 12'h0fc |=> prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_prdata_hold;
        !rd_set |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved");
    property p_mask_off;
        wr_mask0 |=> ##1 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq unmasked");
endmodule
`default_nettype wire

//--- sim/cfs_status_tb.sv
// Purpose: Self-checking bench for the CAN FD status block.
// Assumes: Zero wait state APB slave; events are same-clock pulses.
// Notes:   Queue stride taken equal to the FIFO stride.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        pready, pslverr, irq, bus_off_out;
    logic        evt_push, evt_pop, txq_push, txq_pop;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [6:0]  fifo_push, fifo_pop;
    logic [9:0]  ev;
    int          fails, n_checks;

    cfs_status_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .fifo_push, .fifo_pop,
        .evt_push, .evt_pop, .txq_push, .txq_pop, .nom_tx_err(ev[0]),
        .nom_tx_ok(ev[1]), .nom_rx_err(ev[2]), .nom_rx_err_major(ev[3]),
        .nom_rx_ok(ev[4]), .dp_tx_err(ev[5]), .dp_tx_ok(ev[6]),
        .dp_rx_err(ev[7]), .dp_rx_ok(ev[8]), .bus_idle_bit(ev[9]),
        .irq, .bus_off_out);
    cfs_can_node node (.pclk, .ev);

    task give_verdict;
        $display("mismatches %0d, comparisons %0d", fails, n_checks);
        if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // One APB transfer, then one idle cycle so psel never toggles twice.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // A user address is two reads: high half first, then low half.
    task ua(input logic [11:0] a, input logic [31:0] e);
        logic [15:0] h;
        apb(1'b0, a, 32'h0);
        h = q[15:0];
        apb(1'b0, a + 12'h004, 32'h0);
        chk({h, q[15:0]}, e);
    endtask
    task pul(input logic [6:0] fp, input logic [6:0] fo, input logic [3:0] r);
        fifo_push <= fp;
        fifo_pop <= fo;
        {evt_push, evt_pop, txq_push, txq_pop} <= r;
        @(posedge pclk);
        fifo_push <= 7'h00;
        fifo_pop <= 7'h00;
        {evt_push, evt_pop, txq_push, txq_pop} <= 4'h0;
        @(posedge pclk);
    endtask

    task t_reset;
        rd(12'h050, 32'h20);
        rd(12'h054, 32'h0);
        rd(12'h058, 32'h0);
        rd(12'h0fc, 32'h0);
        chk({31'h0, bus_off_out}, 32'h1);
    endtask
    task t_config;
        apb(1'b1, 12'h060, 32'h1);
        node.pulse(0, 2, 0);
        rd(12'h054, 32'h0);
        apb(1'b1, 12'h5c, 32'h0);
        rd(12'h050, 32'h0);
        chk({31'h0, bus_off_out}, 32'h0);
    endtask
    task t_fifo;
        pul(7'h03, 7'h00, 4'b1010);
        pul(7'h03, 7'h00, 4'b1010);
        pul(7'h00, 7'h03, 4'b0101);
        ua(12'h000, 32'h90);
        ua(12'h008, 32'hc8);
        ua(12'h010, 32'h100);
        ua(12'h040, 32'h40c);
        ua(12'h048, 32'h690);
    endtask
    task t_errors;
        apb(1'b1, 12'h064, 32'h3f);
        apb(1'b1, 12'h068, 32'h04);
        node.pulse(0, 12, 1);
        rd(12'h054, 32'h6000);
        rd(12'h050, 32'h05);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h064, 32'h04);
        node.pulse(3, 8, 0);
        node.pulse(2, 32, 0);
        rd(12'h050, 32'h07);
        chk({31'h0, irq}, 32'h0);
        node.pulse(0, 4, 1);
        node.pulse(3, 4, 1);
        rd(12'h050, 32'h18);
        node.pulse(1, 1, 0);
        node.pulse(4, 1, 0);
        rd(12'h054, 32'h7f77);
        rd(12'h050, 32'h07);
        node.pulse(0, 16, 0);
        rd(12'h054, 32'hff77);
        rd(12'h050, 32'h13);
        node.pulse(0, 1, 0);
        apb(1'b0, 12'h050, 32'h0);
        chk(q & 32'h20, 32'h20);
        chk({31'h0, bus_off_out}, 32'h1);
        apb(1'b1, 12'h068, 32'h0);
        node.pulse(9, 1408, 0);
        rd(12'h054, 32'h0);
        rd(12'h050, 32'h0);
    endtask
    task t_data_phase;
        apb(1'b1, 12'h058, 32'h1234);
        rd(12'h058, 32'h1234);
        node.pulse(7, 1, 0);
        rd(12'h058, 32'h1235);
        apb(1'b1, 12'h054, 32'hffff);
        rd(12'h054, 32'h0);
        apb(1'b1, 12'h05c, 32'h4);
        apb(1'b0, 12'h050, 32'h0);
        chk(q & 32'h20, 32'h20);
        chk({31'h0, bus_off_out}, 32'h1);
    endtask

    // The clock free-runs at 25 MHz.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // The whole run is under two thousand cycles, so this bound is generous.
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict;
    end
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        {fifo_push, fifo_pop} = 14'h0;
        {evt_push, evt_pop, txq_push, txq_pop} = 4'h0;
        fails = 0;
        n_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_config;
        t_fifo;
        t_errors;
        t_data_phase;
        give_verdict;
    end
endmodule

bind cfs_status_top cfs_status_checker u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .nom_tx_err, .bus_idle_bit, .irq, .bus_off_out);
`default_nettype wire
